//--- sai_anc_inserter.sv
// ancillary packet inserter: apb registers, placement and packet sequencer
// Functional notes
// RQ1 - never overwrite embedded audio or line crc words
// RQ2 - packet order: identifier, secondary identifier, count, user words, checksum
// RQ3 - payload store holds words 0 to 254, each writable
// RQ4 - count word gives the user words that follow, that many are sent
// RQ5 - modes disabled, continuous, and one packet per trigger
// RQ6 - automatic parity sends 8 bits plus parity, manual sends 10 bits
// RQ7 - words stored at 10 bits; parity mode chooses only what is sent
// RQ8 - header, payload and checksum values take 8-bit or 10-bit ranges
// RQ9 - confirmed clear zeroes the store, cancelled clear leaves it
// RQ10 - auto checksum computed, otherwise programmed checksum sent
// RQ11 - line or offset outside the format range means no insertion
// RQ12 - no guard near line end; packet may overwrite timing words
// RQ13 - progressive: one line number picks the line per frame
// RQ14 - interlaced: field select plus separate line per field
// RQ15 - sample offset places the first packet word, counted from sav
// RQ16 - channel select puts the packet in luma or chroma
// RQ17 - in 3g level b, link select picks link a or b
// RQ18 - in dual hd, stream select picks stream 1 or 2
// RQ19 - automatic parity is the reset default
// RQ20 - flag words 000, 3ff, 3ff precede the identifier
// RQ21 - auto checksum: 9-bit sum of low 9 bits, bit 9 inverse of bit 8
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sai_anc_inserter #(
  parameter int UDW_DEPTH = 255
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sai_pkg::sai_vid_t vid_in,
  output sai_pkg::sai_vid_t vid_out,
  output logic inserting
);
  import sai_pkg::*;

  if (UDW_DEPTH < 1 || UDW_DEPTH > UDW_MAX) begin : g_bad_depth
    $error("UDW_DEPTH must lie between 1 and 255");
  end

  logic [CTRL_W-1:0] ctrl;
  logic [9:0] did;
  logic [9:0] sdid;
  logic [9:0] dc;
  logic [9:0] cs;
  logic [10:0] line1;
  logic [10:0] line2;
  logic [10:0] line_max;
  logic [12:0] offset;
  logic [12:0] sample_max;
  logic single_pend;
  logic clr_pend;
  logic [15:0] pkt_cnt;
  sai_state_t state;
  logic [7:0] idx;
  logic [8:0] sum;
  logic [12:0] samp;

  // apb phases and address decode
  wire logic setup = psel & ~penable;
  wire logic wr = psel & penable & pready & pwrite;
  wire logic hit_ctrl = paddr == OFF_CTRL;
  wire logic hit_cmd = paddr == OFF_CMD;
  wire logic hit_did = paddr == OFF_DID;
  wire logic hit_sdid = paddr == OFF_SDID;
  wire logic hit_dc = paddr == OFF_DC;
  wire logic hit_cs = paddr == OFF_CS;
  wire logic hit_line1 = paddr == OFF_LINE1;
  wire logic hit_line2 = paddr == OFF_LINE2;
  wire logic hit_offset = paddr == OFF_OFFSET;
  wire logic hit_lmax = paddr == OFF_LINE_MAX;
  wire logic hit_smax = paddr == OFF_SAMPLE_MAX;
  wire logic hit_status = paddr == OFF_STATUS;
  wire logic [7:0] apb_idx = paddr[9:2];
  wire logic hit_udw = ((paddr & UDW_MASK) == UDW_BASE) && (paddr[1:0] == 2'h0)
                       && (int'(apb_idx) < UDW_DEPTH); // RQ3
  wire logic mapped = hit_ctrl | hit_cmd | hit_did | hit_sdid | hit_dc | hit_cs | hit_line1
                      | hit_line2 | hit_offset | hit_lmax | hit_smax | hit_status | hit_udw;

  // control fields
  wire logic [1:0] mode = ctrl[CTRL_MODE_LSB +: 2];
  wire logic auto_par = ctrl[CTRL_AUTO_PAR];
  wire logic auto_cs = ctrl[CTRL_AUTO_CS];
  wire logic interlaced = ctrl[CTRL_INTERLACED];
  wire logic chroma_sel = ctrl[CTRL_CHROMA];
  wire logic link_sel = ctrl[CTRL_LINK_B];
  wire logic stream_sel = ctrl[CTRL_STREAM2];
  wire logic [1:0] fsel = ctrl[CTRL_FSEL_LSB +: 2];
  wire logic fmt_3gb = ctrl[CTRL_FMT_3GB];
  wire logic fmt_2hd = ctrl[CTRL_FMT_2HD];

  // command strobes; a clear needs a request first, then yes or no
  wire logic cmd_wr = wr & hit_cmd;
  wire logic trig = cmd_wr & pwdata[CMD_TRIGGER] & (mode == MODE_SINGLE);
  wire logic clr_yes = cmd_wr & pwdata[CMD_CLR_YES] & clr_pend;
  wire logic clr_no = cmd_wr & pwdata[CMD_CLR_NO];
  wire logic store_clr = clr_yes; // RQ9

  wire logic [9:0] udw_apb;
  wire logic [9:0] udw_pkt;
  wire logic busy = state != ST_IDLE;
  wire logic [31:0] status = {pkt_cnt, 13'h0000, busy, clr_pend, single_pend};

  // read data selection, unmapped and command addresses read zero
  wire logic [31:0] rd_data =
    hit_ctrl ? {20'h00000, ctrl} :
    hit_did ? {22'h000000, did} :
    hit_sdid ? {22'h000000, sdid} :
    hit_dc ? {22'h000000, dc} :
    hit_cs ? {22'h000000, cs} :
    hit_line1 ? {21'h000000, line1} :
    hit_line2 ? {21'h000000, line2} :
    hit_offset ? {19'h00000, offset} :
    hit_lmax ? {21'h000000, line_max} :
    hit_smax ? {19'h00000, sample_max} :
    hit_status ? status :
    hit_udw ? {22'h000000, udw_apb} : 32'h00000000;

  // one wait-free access: answer prepared during setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rd_data : prdata;
    end
  end

  // configuration registers hold full 10-bit values in either parity mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST; // RQ19
      did <= '0;
      sdid <= '0;
      dc <= '0;
      cs <= '0;
      line1 <= LINE_RST;
      line2 <= LINE_RST;
      offset <= '0;
      line_max <= LINE_MAX_RST;
      sample_max <= SAMPLE_MAX_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl <= pwdata[CTRL_W-1:0];
      if (hit_did) did <= pwdata[WORD_W-1:0]; // RQ8
      if (hit_sdid) sdid <= pwdata[WORD_W-1:0]; // RQ8
      if (hit_dc) dc <= pwdata[WORD_W-1:0]; // RQ8
      if (hit_cs) cs <= pwdata[WORD_W-1:0]; // RQ8
      if (hit_line1) line1 <= pwdata[LINE_W-1:0];
      if (hit_line2) line2 <= pwdata[LINE_W-1:0];
      if (hit_offset) offset <= pwdata[SAMP_W-1:0];
      if (hit_lmax) line_max <= pwdata[LINE_W-1:0];
      if (hit_smax) sample_max <= pwdata[SAMP_W-1:0];
    end
  end

  // placement: context, line, field, sample position and range
  wire logic ctx_ok = (!fmt_3gb || vid_in.link_b == link_sel) // RQ17
                      && (!fmt_2hd || vid_in.stream2 == stream_sel); // RQ18
  wire logic [12:0] pos = vid_in.sav ? 13'h0000 : samp; // RQ15
  wire logic f1_hit = !vid_in.field2 && fsel[0] && vid_in.line == line1;
  wire logic f2_hit = vid_in.field2 && fsel[1] && vid_in.line == line2;
  wire logic line_hit = interlaced ? (f1_hit | f2_hit) : (vid_in.line == line1); // RQ13 RQ14
  wire logic [10:0] cur_line = (interlaced && vid_in.field2) ? line2 : line1;
  wire logic in_range = (cur_line <= line_max) && (offset <= sample_max); // RQ11
  wire logic mode_on = (mode == MODE_CONT) || (mode == MODE_SINGLE && single_pend); // RQ5
  wire logic prot_now = chroma_sel ? vid_in.c_prot : vid_in.y_prot; // RQ16
  wire logic start = !busy && ctx_ok && mode_on && line_hit && in_range && pos == offset;

  // sequencer view of the current slot
  wire logic emit = start || (busy && ctx_ok);
  wire logic emit_ok = emit && !prot_now; // RQ1
  wire sai_state_t es = start ? ST_ADF : state;
  wire logic [7:0] eidx = start ? 8'h00 : idx;
  wire logic [7:0] dc_cnt = (int'(dc[7:0]) > UDW_DEPTH) ? 8'(UDW_DEPTH) : dc[7:0]; // RQ4
  wire logic [8:0] cs_auto = sum; // RQ21
  wire logic [9:0] hdr_raw = (eidx == 8'h00) ? did : (eidx == 8'h01) ? sdid : dc;
  wire logic [9:0] raw =
    (es == ST_ADF) ? ((eidx == 8'h00) ? ADF_ZERO : ADF_ONES) : // RQ20
    (es == ST_HDR) ? hdr_raw :
    (es == ST_UDW) ? udw_pkt :
    auto_cs ? {~cs_auto[8], cs_auto} : cs; // RQ10 RQ21
  wire logic bypass = (es == ST_ADF) || (es == ST_CS && auto_cs);
  wire logic [9:0] word;
  wire logic done = emit_ok && es == ST_CS;

  sai_word_fmt u_fmt (
    .raw(raw),
    .auto_par(auto_par),
    .bypass(bypass),
    .word(word)
  ); // RQ6 RQ7

  sai_udw_store #(
    .DEPTH(UDW_DEPTH),
    .IDX_W(UDW_IDX_W),
    .W(WORD_W)
  ) u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr & hit_udw),
    .wr_idx(apb_idx),
    .wr_data(pwdata[WORD_W-1:0]),
    .clr(store_clr),
    .rd_a_idx(apb_idx),
    .rd_a_data(udw_apb),
    .rd_b_idx(eidx),
    .rd_b_data(udw_pkt)
  ); // RQ3 RQ7

  // next state: flags, header, payload, checksum; a protected slot aborts
  sai_state_t next_state;
  logic [7:0] next_idx;
  always_comb begin
    next_state = state;
    next_idx = idx;
    if (emit && prot_now) begin
      next_state = ST_IDLE; // RQ1
      next_idx = 8'h00;
    end else if (emit) begin
      unique case (es)
        ST_IDLE: next_state = ST_IDLE;
        ST_ADF: begin
          next_state = (eidx == 8'h02) ? ST_HDR : ST_ADF; // RQ2
          next_idx = (eidx == 8'h02) ? 8'h00 : eidx + 8'h01;
        end
        ST_HDR: begin
          next_state = (eidx != 8'h02) ? ST_HDR : (dc_cnt == 8'h00) ? ST_CS : ST_UDW; // RQ2 RQ4
          next_idx = (eidx == 8'h02) ? 8'h00 : eidx + 8'h01;
        end
        ST_UDW: begin
          next_state = (eidx == dc_cnt - 8'h01) ? ST_CS : ST_UDW; // RQ4
          next_idx = (eidx == dc_cnt - 8'h01) ? 8'h00 : eidx + 8'h01;
        end
        ST_CS: begin
          next_state = ST_IDLE;
          next_idx = 8'h00;
        end
      endcase
    end
  end

  // checksum sums the words as sent, from identifier to last payload word
  wire logic sum_step = emit_ok && (es == ST_HDR || es == ST_UDW);
  wire logic [8:0] next_sum = (es == ST_HDR && eidx == 8'h00) ? word[8:0] : 9'(sum + word[8:0]); // RQ21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      idx <= 8'h00;
      sum <= 9'h000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      sum <= sum_step ? next_sum : sum;
    end
  end

  // sample position counts only the words of the chosen link or stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) samp <= 13'h0000;
    else if (ctx_ok) samp <= 13'(pos + 13'h0001); // RQ15
  end

  // a trigger landing in the done cycle is kept for the next field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_pend <= 1'b0;
      clr_pend <= 1'b0;
      pkt_cnt <= 16'h0000;
    end else begin
      single_pend <= trig | (single_pend & ~done & (mode == MODE_SINGLE)); // RQ5
      clr_pend <= (cmd_wr & pwdata[CMD_CLR_REQ]) | (clr_pend & ~clr_yes & ~clr_no); // RQ9
      pkt_cnt <= done ? pkt_cnt + 16'h0001 : pkt_cnt;
    end
  end

  // output stage: no guard against running over eav or sav, by design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vid_out <= '0;
      inserting <= 1'b0;
    end else begin
      vid_out <= vid_in;
      inserting <= emit_ok;
      if (emit_ok && !chroma_sel) vid_out.y <= word; // RQ12 RQ16
      if (emit_ok && chroma_sel) vid_out.c <= word; // RQ12 RQ16
    end
  end

  // checks
  sequence s_flag_tail;
    (state == ST_ADF && idx == 8'h01 && ctx_ok && !prot_now) ##1
    (state == ST_ADF && idx == 8'h02 && ctx_ok && !prot_now);
  endsequence

  // a protected slot on the chosen channel leaves both channels as they came in
  property p_no_prot_overwrite;
    @(posedge pclk) disable iff (!presetn)
    prot_now |=> !inserting && vid_out.y == $past(vid_in.y) && vid_out.c == $past(vid_in.c);
  endproperty
  a_no_prot_overwrite: assert property (p_no_prot_overwrite) else $error("protected slot overwritten"); // RQ1

  property p_flag_words;
    @(posedge pclk) disable iff (!presetn)
    (start && !prot_now) |=> inserting && !chroma_sel |-> vid_out.y == ADF_ZERO;
  endproperty
  a_flag_words: assert property (p_flag_words) else $error("first flag word not zero"); // RQ20

  property p_id_after_flags;
    @(posedge pclk) disable iff (!presetn)
    s_flag_tail |=> (state == ST_HDR && idx == 8'h00);
  endproperty
  a_id_after_flags: assert property (p_id_after_flags) else $error("identifier not after flags"); // RQ2

  property p_auto_parity;
    @(posedge pclk) disable iff (!presetn)
    (emit_ok && auto_par && (es == ST_HDR || es == ST_UDW))
      |-> (word[8] == ^word[7:0]) && (word[9] == ~word[8]);
  endproperty
  a_auto_parity: assert property (p_auto_parity) else $error("bad generated parity"); // RQ6

  property p_manual_raw;
    @(posedge pclk) disable iff (!presetn)
    (emit_ok && !auto_par && es == ST_UDW) |=> ($past(chroma_sel) ? vid_out.c : vid_out.y) == $past(udw_pkt);
  endproperty
  a_manual_raw: assert property (p_manual_raw) else $error("manual word altered"); // RQ7

  property p_udw_count;
    @(posedge pclk) disable iff (!presetn)
    (state == ST_UDW && $past(state) == ST_HDR) |-> dc_cnt != 8'h00 ##0 (idx == 8'h00);
  endproperty
  a_udw_count: assert property (p_udw_count) else $error("payload entered with zero count"); // RQ4

  property p_disabled_idle;
    @(posedge pclk) disable iff (!presetn)
    (mode == MODE_DISABLE && !busy) |=> !busy;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("packet started while disabled"); // RQ5

  property p_range_blocks;
    @(posedge pclk) disable iff (!presetn)
    (!in_range && !busy) |=> !inserting;
  endproperty
  a_range_blocks: assert property (p_range_blocks) else $error("packet out of range inserted"); // RQ11

  property p_clear_cancel;
    @(posedge pclk) disable iff (!presetn)
    clr_no |=> !clr_pend [*2];
  endproperty
  a_clear_cancel: assert property (p_clear_cancel) else $error("clear still pending after cancel"); // RQ9

endmodule // sai_anc_inserter
`default_nettype wire

//--- sai_pkg.sv
// shared constants, register map and types of the ancillary packet inserter
package sai_pkg;

  // register byte offsets on the apb slave
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  localparam logic [11:0] OFF_DID = 12'h008;
  localparam logic [11:0] OFF_SDID = 12'h00c;
  localparam logic [11:0] OFF_DC = 12'h010;
  localparam logic [11:0] OFF_CS = 12'h014;
  localparam logic [11:0] OFF_LINE1 = 12'h018;
  localparam logic [11:0] OFF_LINE2 = 12'h01c;
  localparam logic [11:0] OFF_OFFSET = 12'h020;
  localparam logic [11:0] OFF_LINE_MAX = 12'h024;
  localparam logic [11:0] OFF_SAMPLE_MAX = 12'h028;
  localparam logic [11:0] OFF_STATUS = 12'h02c;
  localparam logic [11:0] UDW_BASE = 12'h400;
  localparam logic [11:0] UDW_MASK = 12'hc00;

  // control register fields
  localparam int CTRL_W = 12;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_AUTO_PAR = 2;
  localparam int CTRL_AUTO_CS = 3;
  localparam int CTRL_INTERLACED = 4;
  localparam int CTRL_CHROMA = 5;
  localparam int CTRL_LINK_B = 6;
  localparam int CTRL_STREAM2 = 7;
  localparam int CTRL_FSEL_LSB = 8;
  localparam int CTRL_FMT_3GB = 10;
  localparam int CTRL_FMT_2HD = 11;
  localparam logic [11:0] CTRL_RST = 12'h30c;

  // command register bits, write only
  localparam int CMD_TRIGGER = 0;
  localparam int CMD_CLR_REQ = 1;
  localparam int CMD_CLR_YES = 2;
  localparam int CMD_CLR_NO = 3;

  // output modes
  localparam logic [1:0] MODE_DISABLE = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;

  // widths and reset values
  localparam int WORD_W = 10;
  localparam int LINE_W = 11;
  localparam int SAMP_W = 13;
  localparam int UDW_IDX_W = 8;
  localparam int UDW_MAX = 255;
  localparam logic [10:0] LINE_RST = 11'h009;
  localparam logic [10:0] LINE_MAX_RST = 11'h7ff;
  localparam logic [12:0] SAMPLE_MAX_RST = 13'h1fff;

  // ancillary data flag words
  localparam logic [9:0] ADF_ZERO = 10'h000;
  localparam logic [9:0] ADF_ONES = 10'h3ff;

  typedef enum logic [2:0] {ST_IDLE, ST_ADF, ST_HDR, ST_UDW, ST_CS} sai_state_t;

  // one word slot of the video stream, luma and chroma side by side
  typedef struct packed {
    logic [9:0] y;
    logic [9:0] c;
    logic y_prot;
    logic c_prot;
    logic sav;
    logic [10:0] line;
    logic field2;
    logic link_b;
    logic stream2;
  } sai_vid_t;

endpackage

//--- sai_sink_model.sv
// receiving side of the video link: records every word the inserter marks
`timescale 1ns/1ps
`default_nettype none
module sai_sink_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic chroma,
  input wire sai_pkg::sai_vid_t vid,
  input wire logic inserting
);
  import sai_pkg::*;
  logic [9:0] cap [0:299];
  int n;

  // capture only the watched channel; the store is bounded so a runaway packet cannot overrun it
  always @(posedge pclk) begin
    if (clr) begin
      n <= 0;
    end else if (inserting && n < 300) begin
      cap[n] <= chroma ? vid.c : vid.y;
      n <= n + 1;
    end
  end
endmodule // sai_sink_model
`default_nettype wire

//--- sai_udw_store.sv
// payload word store with one write port, two read ports and a whole clear
`timescale 1ns/1ps
`default_nettype none
module sai_udw_store #(
  parameter int DEPTH = 255,
  parameter int IDX_W = 8,
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic clr,
  input wire logic [IDX_W-1:0] rd_a_idx,
  output logic [W-1:0] rd_a_data,
  input wire logic [IDX_W-1:0] rd_b_idx,
  output logic [W-1:0] rd_b_data
);
  logic [W-1:0] mem [DEPTH];

  // clear wins over a write in the same cycle, full word kept at every width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (wr_en && int'(wr_idx) < DEPTH) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // out of range indices read as zero
  assign rd_a_data = (int'(rd_a_idx) < DEPTH) ? mem[rd_a_idx] : '0;
  assign rd_b_data = (int'(rd_b_idx) < DEPTH) ? mem[rd_b_idx] : '0;
endmodule // sai_udw_store
`default_nettype wire

//--- sai_word_fmt.sv
// formats one packet word: generated parity or the stored word as entered
`timescale 1ns/1ps
`default_nettype none
module sai_word_fmt (
  input wire logic [9:0] raw,
  input wire logic auto_par,
  input wire logic bypass,
  output logic [9:0] word
);
  // bit 8 makes bits 0..8 even, bit 9 is its inverse
  wire logic par = ^raw[7:0];
  assign word = (bypass || !auto_par) ? raw : {~par, par, raw[7:0]};
endmodule // sai_word_fmt
`default_nettype wire

//--- tb.sv
// testbench of the ancillary packet inserter: apb tasks, video source and packet checks
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sai_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, inserting, clr, chroma, prot_on, last_err, dual;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, ctl;
  sai_vid_t vin, vout;
  int err_total, checks_done, cyc, sp, ln, nsp, nln, plen;
  logic [9:0] e [0:299];

  sai_anc_inserter #(.UDW_DEPTH(255)) sai_anc_inserter_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vid_in(vin), .vid_out(vout), .inserting(inserting));
  sai_sink_model sai_sink_model_i (.pclk(pclk), .clr(clr), .chroma(chroma), .vid(vout), .inserting(inserting));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // video source: frames of 12 lines of 64 samples, lines 7 to 12 are field 2, odd slots are link b and
  // stream 2; dual marks sav on both interleaved links and moves the protected slot from 3 to even slot 6
  always @(posedge pclk) begin
    nsp = (sp == 63) ? 0 : sp + 1;
    nln = (sp != 63) ? ln : ((ln == 12) ? 1 : ln + 1);
    sp <= nsp;
    ln <= nln;
    vin.sav <= (nsp == 0) || (dual && nsp == 1);
    vin.line <= 11'(nln);
    vin.field2 <= (nln > 6);
    vin.link_b <= nsp[0];
    vin.stream2 <= nsp[0];
    vin.y <= 10'($urandom);
    vin.c <= 10'($urandom);
    vin.y_prot <= prot_on && nln == 5 && nsp == (dual ? 6 : 3);
    vin.c_prot <= prot_on && nln == 5 && nsp == (dual ? 6 : 3);
  end

  // hang guard, well above the roughly 20 frames the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      results();
    end
  end

  function automatic logic [9:0] fmt(input logic [9:0] v, input logic ap);
    logic p;
    p = ^v[7:0];
    return ap ? {~p, p, v[7:0]} : v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_l1;
    do @(posedge pclk); while (!(ln == 1 && sp == 0));
  endtask

  // capture exactly one whole frame at the sink
  task automatic frame;
    wait_l1();
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    wait_l1();
  endtask

  task automatic pkt(input int n, input logic ap, input logic acs, input logic ch);
    logic [9:0] did, sdid, cs, u;
    logic [8:0] s;
    did = 10'($urandom);
    sdid = 10'($urandom);
    cs = 10'($urandom);
    apb(1'b1, OFF_DID, {22'h0, did});
    apb(1'b1, OFF_SDID, {22'h0, sdid});
    apb(1'b1, OFF_DC, 32'(n));
    apb(1'b1, OFF_CS, {22'h0, cs});
    e[0] = ADF_ZERO;
    e[1] = ADF_ONES;
    e[2] = ADF_ONES;
    e[3] = fmt(did, ap);
    e[4] = fmt(sdid, ap);
    e[5] = fmt(10'(n), ap);
    for (int i = 0; i < n; i++) begin
      u = 10'($urandom);
      apb(1'b1, UDW_BASE + 12'(4 * i), {22'h0, u});
      e[6 + i] = fmt(u, ap);
    end
    s = 9'h0;
    for (int i = 3; i < 6 + n; i++) s = s + e[i][8:0];
    e[6 + n] = acs ? {~s[8], s} : fmt(cs, ap);
    plen = 7 + n;
    chroma <= ch;
    ctl = 32'h300 | 32'(MODE_CONT) | (32'(ap) << CTRL_AUTO_PAR) | (32'(acs) << CTRL_AUTO_CS) | (32'(ch) << CTRL_CHROMA);
    apb(1'b1, OFF_CTRL, ctl);
    frame();
    cmp_pkt();
  endtask

  // the frame just captured must hold exactly the expected packet
  task automatic cmp_pkt;
    chk("packet length", sai_sink_model_i.n, 32'(plen));
    for (int i = 0; i < plen; i++) chk("packet word", {22'h0, sai_sink_model_i.cap[i]}, {22'h0, e[i]});
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vin = '0;
    clr = 1'b0;
    chroma = 1'b0;
    prot_on = 1'b0;
    dual = 1'b0;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    sp = 0;
    ln = 1;
    void'($urandom(69));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", q, 32'(CTRL_RST));
    apb(1'b1, OFF_LINE1, 32'h5);
    apb(1'b1, OFF_OFFSET, 32'h3);
    // payload store corners, full width kept, index 255 refused
    apb(1'b1, UDW_BASE, 32'h3a5);
    apb(1'b1, UDW_BASE + 12'h3f8, 32'h15a);
    apb(1'b0, UDW_BASE, 32'h0);
    chk("payload word 0", q, 32'h3a5);
    apb(1'b0, UDW_BASE + 12'h3f8, 32'h0);
    chk("payload word 254", q, 32'h15a);
    apb(1'b1, UDW_BASE + 12'h3fc, 32'h1);
    chk("payload index 255 error", 32'(last_err), 32'h1);
    // packets: auto parity and checksum, empty payload, manual 10-bit in chroma
    pkt(8, 1'b1, 1'b1, 1'b0);
    pkt(0, 1'b1, 1'b0, 1'b0);
    pkt($urandom_range(1, 8), 1'b0, 1'b0, 1'b1);
    apb(1'b1, OFF_LINE_MAX, 32'h4);
    frame();
    chk("line out of range", sai_sink_model_i.n, 32'h0);
    apb(1'b1, OFF_LINE_MAX, 32'h7ff);
    prot_on <= 1'b1;
    frame();
    chk("protected slot", sai_sink_model_i.n, 32'h0);
    // 3g level b on link b, then dual hd on stream 2: the packet must keep to odd slots and so miss
    // the protected even slot 6 that a wrong link or stream choice would run into
    dual <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CTRL, ctl | (32'h1 << (CTRL_FMT_3GB + k)) | (32'h1 << (CTRL_LINK_B + k)));
      frame();
      cmp_pkt();
    end
    prot_on <= 1'b0;
    dual <= 1'b0;
    // interlaced, field 2 only: one packet on line 8 of field 2, none on line 5 of field 1
    apb(1'b1, OFF_LINE2, 32'h8);
    apb(1'b1, OFF_CTRL, (ctl & ~32'h100) | (32'h1 << CTRL_INTERLACED));
    frame();
    cmp_pkt();
    // one trigger gives one packet across two frames, then disabled gives none
    apb(1'b1, OFF_CTRL, (ctl & ~32'h3) | 32'(MODE_SINGLE));
    wait_l1();
    clr <= 1'b1;
    apb(1'b1, OFF_CMD, 32'h1 << CMD_TRIGGER);
    clr <= 1'b0;
    wait_l1();
    wait_l1();
    chk("single packet count", sai_sink_model_i.n, 32'(plen));
    apb(1'b1, OFF_CTRL, ctl & ~32'h3);
    frame();
    chk("disabled count", sai_sink_model_i.n, 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status flags idle", q & 32'h7, 32'h0);
    // clear cancelled, then confirmed
    apb(1'b1, UDW_BASE, 32'h2c7);
    apb(1'b1, OFF_CMD, 32'h1 << CMD_CLR_REQ);
    apb(1'b1, OFF_CMD, 32'h1 << CMD_CLR_NO);
    apb(1'b0, UDW_BASE, 32'h0);
    chk("payload after cancel", q, 32'h2c7);
    apb(1'b1, OFF_CMD, 32'h1 << CMD_CLR_REQ);
    apb(1'b1, OFF_CMD, 32'h1 << CMD_CLR_YES);
    apb(1'b0, UDW_BASE, 32'h0);
    chk("payload 0 after clear", q, 32'h0);
    apb(1'b0, UDW_BASE + 12'h3f8, 32'h0);
    chk("payload 254 after clear", q, 32'h0);
    results();
  end
endmodule // tb
`default_nettype wire
